// >>> icn_bench.sv
`timescale 1ns/1ps
module icn_bench;
  import icn_pkg::*;
  logic        clock, reset_n, awvalid, wvalid, bready, arvalid, rready, wake_seen;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic [21:0] drive_val, float_mask;
  wire         awready, wready, bvalid, arready, rvalid, change_irq, sleep_wake;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [21:0] pins, pu_en;
  int          errors, checked, cycles;
  icn_top dut (.clock(clock), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .change_input(pins), .change_input_pullup_enable(pu_en),
    .change_irq(change_irq), .sleep_wake(sleep_wake));
  icn_pin_model u_pins (.clock(clock), .drive_val(drive_val), .float_mask(float_mask),
    .pullup_en(pu_en), .pins(pins));
  always #12.5 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (sleep_wake === 1'b1) wake_seen = 1'b1;
    if (cycles == 20000) begin
      errors++;
      complete_run();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er);
    @(posedge clock);
    awaddr <= {2'b00, idx, 2'b00};
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    check("bresp", {30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clock);
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    check("rdata", rdata, ed);
    check("rresp", {30'h0, rresp}, {30'h0, er});
  endtask
  // Latency is fixed: pin model edge, then request edge, with the compare in the same cycle
  task automatic toggle_and_wait(input int i, input logic exp);
    @(posedge clock);
    drive_val[i] <= ~drive_val[i];
    repeat (6) @(posedge clock);
    check("change_irq", {31'h0, change_irq}, {31'h0, exp});
  endtask
  task automatic reg_map;
    logic [7:0]  ix [4] = '{ICN_IDX_EN_LOW, ICN_IDX_EN_HIGH, ICN_IDX_PU_LOW, ICN_IDX_PU_HIGH};
    logic [31:0] ex [4] = '{32'h0000ffff, 32'h0000003f, 32'h0000ffff, 32'h0000003f};
    for (int k = 0; k < 4; k++) begin
      rd(ix[k], 32'h0, ICN_RESP_OKAY);
      wr(ix[k], 32'hffff_ffff, ICN_RESP_OKAY);
      rd(ix[k], ex[k], ICN_RESP_OKAY);
    end
    check("pullups", {10'h0, pu_en}, 32'h003f_ffff);
    wr(8'hff, 32'h1, ICN_RESP_SLVERR);
    rd(8'hff, 32'h0, ICN_RESP_SLVERR);
  endtask
  // Every input, both directions, each change reported exactly once
  task automatic all_inputs;
    wr(ICN_IDX_IRQ_MASK, 32'h1, ICN_RESP_OKAY);
    for (int n = 0; n < 2 * ICN_NUM_IN; n++) begin
      toggle_and_wait(n / 2, 1'b1);
      rd(ICN_IDX_STATUS, 32'h1, ICN_RESP_OKAY);
      wr(ICN_IDX_CLEAR, 32'h1, ICN_RESP_OKAY);
      rd(ICN_IDX_STATUS, 32'h0, ICN_RESP_OKAY);
      check("change_irq", {31'h0, change_irq}, 32'h0);
    end
    check("sleep_wake", {31'h0, wake_seen}, 32'h1);
  endtask
  task automatic gating;
    wr(ICN_IDX_EN_HIGH, 32'h0, ICN_RESP_OKAY);
    wr(ICN_IDX_EN_LOW, 32'h1, ICN_RESP_OKAY);
    wr(ICN_IDX_PU_HIGH, 32'h0, ICN_RESP_OKAY);
    // Output register follows the word one edge later
    @(posedge clock);
    check("pullups_high", {26'h0, pu_en[21:16]}, 32'h0);
    float_mask <= 22'h10_0000;
    toggle_and_wait(5, 1'b0);
    rd(ICN_IDX_STATUS, 32'h0, ICN_RESP_OKAY);
    float_mask <= 22'h0;
    wr(ICN_IDX_IRQ_MASK, 32'h0, ICN_RESP_OKAY);
    toggle_and_wait(0, 1'b0);
    rd(ICN_IDX_STATUS, 32'h1, ICN_RESP_OKAY);
    wr(ICN_IDX_IRQ_MASK, 32'h1, ICN_RESP_OKAY);
    @(posedge clock);
    check("change_irq", {31'h0, change_irq}, 32'h1);
    wr(ICN_IDX_CLEAR, 32'h1, ICN_RESP_OKAY);
    @(posedge clock);
    check("change_irq", {31'h0, change_irq}, 32'h0);
    rd(ICN_IDX_PINS, {10'h0, drive_val}, ICN_RESP_OKAY);
  endtask
  task automatic complete_run;
    $display("Checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    {clock, reset_n, awvalid, wvalid, bready, arvalid, rready, wake_seen} = '0;
    {awaddr, araddr, wdata, drive_val, float_mask} = '0;
    wstrb = 4'hf;
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    reg_map();
    all_inputs();
    gating();
    complete_run();
  end
endmodule

// >>> icn_change_bit.sv
`timescale 1ns/1ps
module icn_change_bit (
  // Clock and reset
  input  wire logic clock,
  input  wire logic reset_n,
  // Pin and enable
  input  wire logic pin,
  input  wire logic enable,
  // Detection
  output logic      changed
);
  logic last_ff;
  logic nxt_last;

  // Follows the pin while disabled, so enabling raises no stale change
  assign nxt_last = pin; // [R9]
  assign changed  = enable & (pin ^ last_ff); // [R1] [R9]

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      last_ff <= 1'b0;
    end else begin
      last_ff <= nxt_last;
    end
  end
endmodule

// >>> icn_checker_assertions.sv
`timescale 1ns/1ps
module icn_checker #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  // Clock and reset
  input  wire logic                           clock,
  input  wire logic                           reset_n,
  // Register bus
  input  wire logic [icn_pkg::ICN_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                           s_axi_awvalid,
  input  wire logic                           s_axi_awready,
  input  wire logic [31:0]                    s_axi_wdata,
  input  wire logic                           s_axi_wvalid,
  input  wire logic                           s_axi_wready,
  input  wire logic                           s_axi_bvalid,
  input  wire logic [icn_pkg::ICN_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                           s_axi_arvalid,
  input  wire logic                           s_axi_arready,
  input  wire logic [31:0]                    s_axi_rdata,
  input  wire logic                           s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  // Pins and requests
  input  wire logic [icn_pkg::ICN_NUM_IN-1:0] change_input,
  input  wire logic [icn_pkg::ICN_NUM_IN-1:0] change_input_pullup_enable,
  input  wire logic                           change_irq,
  input  wire logic                           sleep_wake
);
  import icn_pkg::*;
  localparam logic [ICN_ADDR_W-1:0] PU_LOW_ADDR  = {2'b00, ICN_IDX_PU_LOW, 2'b00};
  localparam logic [ICN_ADDR_W-1:0] PU_HIGH_ADDR = {2'b00, ICN_IDX_PU_HIGH, 2'b00};
  logic                  wr_take;
  logic [ICN_ADDR_W-1:0] rd_addr_ff;
  logic                  four_words;
  assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // Address of the read under way; the zero upper half check covers only the four words
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rd_addr_ff <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_addr_ff <= s_axi_araddr;
    end
  end
  assign four_words = (rd_addr_ff[ICN_ADDR_W-1:10] == '0) && (rd_addr_ff[1:0] == 2'b00)
                      && (rd_addr_ff[9:2] inside {ICN_IDX_EN_LOW, ICN_IDX_EN_HIGH,
                                                  ICN_IDX_PU_LOW, ICN_IDX_PU_HIGH});
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Word register, then output register: two edges after the write
  property p_pu_low;
    wr_take && s_axi_awaddr == PU_LOW_ADDR
      |-> ##2 change_input_pullup_enable[15:0] == $past(s_axi_wdata[15:0], 2);
  endproperty
  a_pu_low: assert property (p_pu_low) else $error("low pull-up word not applied");
  property p_pu_high;
    LARGE_VARIANT && wr_take && s_axi_awaddr == PU_HIGH_ADDR
      |-> ##2 change_input_pullup_enable[21:16] == $past(s_axi_wdata[5:0], 2);
  endproperty
  a_pu_high: assert property (p_pu_high) else $error("high pull-up word not applied");
  property p_rd_upper_zero;
    s_axi_rvalid && four_words |-> s_axi_rdata[31:16] == 16'h0000;
  endproperty
  a_rd_upper_zero: assert property (p_rd_upper_zero) else $error("upper read bits set");
  property p_irq_rise;
    $rose(change_irq) |-> $past(change_input, 1) != $past(change_input, 2) || $past(s_axi_bvalid);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("request without input change");
  property p_irq_fall;
    $fell(change_irq) |-> $past(s_axi_bvalid);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("request dropped without a write");
  property p_write_answer;
    wr_take |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write not answered");
  property p_read_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##0 !s_axi_arready;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_read_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read data not held");
  c_irq: cover property ($rose(change_irq));
  c_wake: cover property (sleep_wake);
  c_write: cover property (wr_take);
endmodule
bind icn_top icn_checker #(.LARGE_VARIANT(LARGE_VARIANT)) u_icn_checker (
  .clock(clock), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .change_input(change_input),
  .change_input_pullup_enable(change_input_pullup_enable), .change_irq(change_irq),
  .sleep_wake(sleep_wake));

// >>> icn_pin_model.sv
`timescale 1ns/1ps
module icn_pin_model (
  // Clock
  input  wire logic                           clock,
  // Bench control
  input  wire logic [icn_pkg::ICN_NUM_IN-1:0] drive_val,
  input  wire logic [icn_pkg::ICN_NUM_IN-1:0] float_mask,
  input  wire logic [icn_pkg::ICN_NUM_IN-1:0] pullup_en,
  // Pins
  output logic      [icn_pkg::ICN_NUM_IN-1:0] pins
);
  import icn_pkg::*;
  logic [ICN_NUM_IN-1:0] pins_ff;
  assign pins = pins_ff;
  // Undriven pin without pull-up wanders, so no stale level is trusted
  always_ff @(posedge clock) begin
    for (int i = 0; i < ICN_NUM_IN; i++) begin
      if (!float_mask[i]) begin
        pins_ff[i] <= drive_val[i];
      end else if (pullup_en[i]) begin
        pins_ff[i] <= 1'b1;
      end else begin
        pins_ff[i] <= ~pins_ff[i];
      end
    end
  end
endmodule

// >>> icn_pkg.sv
package icn_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [7:0]  ICN_IDX_EN_LOW   = 8'hc0;
  localparam logic [7:0]  ICN_IDX_EN_HIGH  = 8'hc2;
  localparam logic [7:0]  ICN_IDX_PU_LOW   = 8'hc4;
  localparam logic [7:0]  ICN_IDX_PU_HIGH  = 8'hc6;
  localparam logic [7:0]  ICN_IDX_STATUS   = 8'hc8;
  localparam logic [7:0]  ICN_IDX_CLEAR    = 8'hc9;
  localparam logic [7:0]  ICN_IDX_IRQ_MASK = 8'hca;
  localparam logic [7:0]  ICN_IDX_PINS     = 8'hcb;
  localparam int          ICN_ADDR_W       = 12;
  localparam int          ICN_NUM_IN       = 22;
  localparam int          ICN_HIGH_W_LARGE = 6;
  localparam int          ICN_HIGH_W_SMALL = 3;
  localparam logic [15:0] ICN_REG_RESET    = 16'h0000;
  localparam logic [1:0]  ICN_RESP_OKAY    = 2'b00;
  localparam logic [1:0]  ICN_RESP_SLVERR  = 2'b10;
  localparam int          ICN_EV_CHANGE    = 0;
  localparam int          ICN_EV_W         = 1;
  typedef enum logic [2:0] {
    ICN_BUS_IDLE = 3'b001,
    ICN_BUS_RESP = 3'b010,
    ICN_BUS_HOLD = 3'b100
  } icn_bus_state_t;
endpackage

// >>> icn_top.sv
// Function
// R1 - A request is raised whenever an enabled input changes level, either way.
// R2 - Changes are still detected and signalled while the clock is stopped. Here sleep_wake is registered on clock, so it needs the clock running.
// R3 - There are 22 change inputs, each selectable on its own.
// R4 - Enable words at c0 (inputs 15-0) and c2 (upper inputs) gate the request.
// R5 - Word c4 bit n turns on the weak pull-up of input n, n from 0 to 15.
// R6 - Word c6 holds upper pull-ups; all four words reset to zero.
// R7 - Unimplemented bits of the four words always read zero.
// R8 - The larger variant uses bits 5-0 of the upper words for inputs 21-16.
// R9 - Each input is compared with its last value so each change reports once.
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
module icn_top #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  // Clock and reset
  input  wire logic                             clock,
  input  wire logic                             reset_n,
  // AXI4-Lite write address
  input  wire logic [icn_pkg::ICN_ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]                       s_axi_awprot,
  input  wire logic                             s_axi_awvalid,
  output logic                                  s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]                      s_axi_wdata,
  input  wire logic [3:0]                       s_axi_wstrb,
  input  wire logic                             s_axi_wvalid,
  output logic                                  s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                            s_axi_bresp,
  output logic                                  s_axi_bvalid,
  input  wire logic                             s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [icn_pkg::ICN_ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]                       s_axi_arprot,
  input  wire logic                             s_axi_arvalid,
  output logic                                  s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                           s_axi_rdata,
  output logic [1:0]                            s_axi_rresp,
  output logic                                  s_axi_rvalid,
  input  wire logic                             s_axi_rready,
  // Change inputs and pull-up controls
  input  wire logic [icn_pkg::ICN_NUM_IN-1:0]   change_input,
  output logic [icn_pkg::ICN_NUM_IN-1:0]        change_input_pullup_enable,
  // Requests
  output logic                                  change_irq,
  output logic                                  sleep_wake
);
  import icn_pkg::*;

  localparam int HIGH_W = LARGE_VARIANT ? ICN_HIGH_W_LARGE : ICN_HIGH_W_SMALL;
  localparam int USED_N = 16 + HIGH_W;
  localparam logic [15:0] HIGH_MASK = 16'((32'h1 << HIGH_W) - 1); // [R7] [R8]

  // Registers
  logic [15:0]           en_low_ff;
  logic [15:0]           en_high_ff;
  logic [15:0]           pu_low_ff;
  logic [15:0]           pu_high_ff;
  logic [ICN_EV_W-1:0]   status_ff;
  logic [ICN_EV_W-1:0]   irq_mask_ff;
  logic                  irq_ff;
  logic                  wake_ff;
  logic [ICN_NUM_IN-1:0] pullup_ff;

  // Bus state
  icn_bus_state_t        wr_state_ff;
  logic                  aw_held_ff;
  logic                  w_held_ff;
  logic [ICN_ADDR_W-1:0] awaddr_ff;
  logic [31:0]           wdata_ff;
  logic [3:0]            wstrb_ff;
  logic                  awready_ff;
  logic                  wready_ff;
  logic                  bvalid_ff;
  logic [1:0]            bresp_ff;
  logic                  arready_ff;
  logic                  rvalid_ff;
  logic [31:0]           rdata_ff;
  logic [1:0]            rresp_ff;

  // Change detection
  logic [ICN_NUM_IN-1:0] irq_enable_vec;
  logic [ICN_NUM_IN-1:0] changed_vec;
  logic                  any_change;
  logic                  wake_comb;

  // Unused upper bits on the small variant stay forced low
  assign irq_enable_vec = ICN_NUM_IN'({en_high_ff & HIGH_MASK, en_low_ff}); // [R4] [R8]

  genvar gi;
  generate
    for (gi = 0; gi < ICN_NUM_IN; gi++) begin : g_bit // [R3]
      if (gi < USED_N) begin : g_used
        icn_change_bit u_bit (
          .clock   (clock),
          .reset_n (reset_n),
          .pin     (change_input[gi]),
          .enable  (irq_enable_vec[gi]),
          .changed (changed_vec[gi])
        );
      end else begin : g_none
        assign changed_vec[gi] = 1'b0;
      end
    end
  endgenerate

  assign any_change = |changed_vec; // [R1]

  // Unclocked path for sleep; registered copy for the output
  icn_wake_latch u_wake (
    .clock   (clock),
    .reset_n (reset_n),
    .pins    (change_input),
    .enables (irq_enable_vec),
    .wake    (wake_comb)
  );

  // Write path decode
  logic                  wr_go;
  logic [ICN_ADDR_W-1:0] wr_addr;
  logic [31:0]           wr_data;
  logic [3:0]            wr_strb;
  logic [7:0]            wr_idx;
  logic                  wr_hit;
  logic [15:0]           wr_mask;
  logic                  clear_hit;

  assign wr_addr = s_axi_awvalid && !aw_held_ff ? s_axi_awaddr : awaddr_ff;
  assign wr_data = s_axi_wvalid && !w_held_ff ? s_axi_wdata : wdata_ff;
  assign wr_strb = s_axi_wvalid && !w_held_ff ? s_axi_wstrb : wstrb_ff;
  assign wr_go = (wr_state_ff == ICN_BUS_IDLE)
                 && (aw_held_ff || s_axi_awvalid) && (w_held_ff || s_axi_wvalid);
  assign wr_idx  = wr_addr[9:2];
  assign wr_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
  assign wr_hit  = (wr_addr[ICN_ADDR_W-1:10] == '0) && (wr_addr[1:0] == 2'b00)
                   && (wr_idx == ICN_IDX_EN_LOW || wr_idx == ICN_IDX_EN_HIGH
                   || wr_idx == ICN_IDX_PU_LOW || wr_idx == ICN_IDX_PU_HIGH
                   || wr_idx == ICN_IDX_STATUS || wr_idx == ICN_IDX_CLEAR
                   || wr_idx == ICN_IDX_IRQ_MASK || wr_idx == ICN_IDX_PINS);
  assign clear_hit = wr_go && wr_hit && (wr_idx == ICN_IDX_CLEAR) && wr_strb[0];

  // Write channel handshake
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wr_state_ff <= ICN_BUS_IDLE;
      aw_held_ff  <= 1'b0;
      w_held_ff   <= 1'b0;
      awaddr_ff   <= '0;
      wdata_ff    <= '0;
      wstrb_ff    <= '0;
      awready_ff  <= 1'b1;
      wready_ff   <= 1'b1;
      bvalid_ff   <= 1'b0;
      bresp_ff    <= ICN_RESP_OKAY;
    end else begin
      case (wr_state_ff)
        ICN_BUS_IDLE: begin
          if (s_axi_awvalid && awready_ff) begin
            aw_held_ff <= 1'b1;
            awaddr_ff  <= s_axi_awaddr;
            awready_ff <= 1'b0;
          end
          if (s_axi_wvalid && wready_ff) begin
            w_held_ff <= 1'b1;
            wdata_ff  <= s_axi_wdata;
            wstrb_ff  <= s_axi_wstrb;
            wready_ff <= 1'b0;
          end
          if (wr_go) begin
            wr_state_ff <= ICN_BUS_RESP;
            awready_ff  <= 1'b0;
            wready_ff   <= 1'b0;
            bvalid_ff   <= 1'b1;
            bresp_ff    <= wr_hit ? ICN_RESP_OKAY : ICN_RESP_SLVERR;
          end
        end
        ICN_BUS_RESP: begin
          if (s_axi_bready) begin
            wr_state_ff <= ICN_BUS_IDLE;
            bvalid_ff   <= 1'b0;
            aw_held_ff  <= 1'b0;
            w_held_ff   <= 1'b0;
            awready_ff  <= 1'b1;
            wready_ff   <= 1'b1;
          end
        end
        default: begin
          wr_state_ff <= ICN_BUS_IDLE;
          bvalid_ff   <= 1'b0;
          awready_ff  <= 1'b1;
          wready_ff   <= 1'b1;
        end
      endcase
    end
  end

  // Configuration registers, byte lanes 0 and 1 only
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      en_low_ff   <= ICN_REG_RESET; // [R6]
      en_high_ff  <= ICN_REG_RESET; // [R6]
      pu_low_ff   <= ICN_REG_RESET; // [R6]
      pu_high_ff  <= ICN_REG_RESET; // [R6]
      irq_mask_ff <= '0;
    end else if (wr_go && wr_hit) begin
      case (wr_idx)
        ICN_IDX_EN_LOW:
          en_low_ff <= (en_low_ff & ~wr_mask) | (wr_data[15:0] & wr_mask); // [R4]
        ICN_IDX_EN_HIGH:
          en_high_ff <= ((en_high_ff & ~wr_mask) | (wr_data[15:0] & wr_mask)) & HIGH_MASK; // [R7]
        ICN_IDX_PU_LOW:
          pu_low_ff <= (pu_low_ff & ~wr_mask) | (wr_data[15:0] & wr_mask); // [R5]
        ICN_IDX_PU_HIGH:
          pu_high_ff <= ((pu_high_ff & ~wr_mask) | (wr_data[15:0] & wr_mask)) & HIGH_MASK; // [R6]
        ICN_IDX_IRQ_MASK: begin
          if (wr_strb[0]) begin
            irq_mask_ff <= wr_data[ICN_EV_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Sticky status; a new change beats a simultaneous clear
  logic [ICN_EV_W-1:0] ev_set;
  assign ev_set = ICN_EV_W'(any_change) << ICN_EV_CHANGE;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      status_ff <= '0;
    end else begin
      status_ff <= (status_ff & ~(clear_hit ? wr_data[ICN_EV_W-1:0] : '0)) | ev_set; // [R1]
    end
  end

  // Registered outputs
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      irq_ff    <= 1'b0;
      wake_ff   <= 1'b0;
      pullup_ff <= '0;
    end else begin
      irq_ff    <= |((status_ff | ev_set) & irq_mask_ff); // [R1]
      wake_ff   <= wake_comb; // [R2]
      pullup_ff <= ICN_NUM_IN'({pu_high_ff & HIGH_MASK, pu_low_ff}); // [R5] [R6] [R8]
    end
  end

  // Read path
  logic [7:0]  rd_idx;
  logic        rd_hit;
  logic [31:0] rd_word;

  assign rd_idx = s_axi_araddr[9:2];

  always_comb begin
    rd_hit  = (s_axi_araddr[ICN_ADDR_W-1:10] == '0) && (s_axi_araddr[1:0] == 2'b00);
    rd_word = 32'h0000_0000;
    case (rd_idx)
      ICN_IDX_EN_LOW:   rd_word = {16'h0000, en_low_ff};
      ICN_IDX_EN_HIGH:  rd_word = {16'h0000, en_high_ff & HIGH_MASK}; // [R7]
      ICN_IDX_PU_LOW:   rd_word = {16'h0000, pu_low_ff};
      ICN_IDX_PU_HIGH:  rd_word = {16'h0000, pu_high_ff & HIGH_MASK}; // [R7]
      ICN_IDX_STATUS:   rd_word = 32'(status_ff);
      ICN_IDX_CLEAR:    rd_word = 32'h0000_0000;
      ICN_IDX_IRQ_MASK: rd_word = 32'(irq_mask_ff);
      ICN_IDX_PINS:     rd_word = 32'(change_input);
      default:          rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= '0;
      rresp_ff   <= ICN_RESP_OKAY;
    end else if (rvalid_ff) begin
      if (s_axi_rready) begin
        rvalid_ff  <= 1'b0;
        arready_ff <= 1'b1;
      end
    end else if (s_axi_arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rdata_ff   <= rd_hit ? rd_word : 32'h0000_0000;
      rresp_ff   <= rd_hit ? ICN_RESP_OKAY : ICN_RESP_SLVERR;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign change_irq    = irq_ff;
  assign sleep_wake    = wake_ff;
  assign change_input_pullup_enable = pullup_ff;
endmodule

// >>> icn_wake_latch.sv
`timescale 1ns/1ps
module icn_wake_latch (
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    reset_n,
  // Raw pins and enables
  input  wire logic [icn_pkg::ICN_NUM_IN-1:0] pins,
  input  wire logic [icn_pkg::ICN_NUM_IN-1:0] enables,
  // Sleep request
  output logic                         wake
);
  import icn_pkg::*;
  logic [ICN_NUM_IN-1:0] snap_ff;
  logic                  wake_ff;

  // Combinational compare keeps working with the clock stopped
  assign wake = wake_ff | (|(enables & (pins ^ snap_ff))); // [R2]

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      snap_ff <= '0;
      wake_ff <= 1'b0;
    end else begin
      snap_ff <= pins;
      // Stretch by one edge so a short change is not lost
      wake_ff <= |(enables & (pins ^ snap_ff)); // [R2]
    end
  end
endmodule
